// ### design/rmps_out_mux.sv
// Output function selector for one remappable pin.
// Assumes the peripheral output signals are synchronous to clock_i.
`timescale 1ns/1ps
`default_nettype none
module rmps_out_mux #(
  parameter int NUM_FUNC = 32
) (
  input  wire logic                clock_i,
  input  wire logic                srst_i,
  input  wire logic [4:0]          sel_i,
  input  wire logic [NUM_FUNC-1:0] func_out_i,
  input  wire logic [NUM_FUNC-1:0] func_oe_i,
  output logic                     pin_out_o,
  output logic                     pin_oe_o
);
  import rmps_pkg::*;

  // Code zero releases the pin; the function table is the parameterised input vector.
  always_ff @(posedge clock_i) begin
    if (srst_i || sel_i == OUT_FUNC_NONE || int'(sel_i) >= NUM_FUNC) begin // R06
      pin_out_o <= 1'b0;
      pin_oe_o  <= 1'b0;
    end else begin
      pin_out_o <= func_out_i[sel_i]; // R06
      pin_oe_o  <= func_oe_i[sel_i];
    end
  end

  a_free_pin_idle: assert property (@(posedge clock_i) disable iff (srst_i) // R06
    ($past(sel_i) == OUT_FUNC_NONE) |-> !pin_oe_o)
    else $error("pin driven while function code is zero");

endmodule : rmps_out_mux
`default_nettype wire

// ### design/rmps_pkg.sv
// Package for the remap selector block: register map, field layouts, reset values.
// Assumes a 16-bit register port with one-cycle read latency.
`default_nettype none
package rmps_pkg;

  localparam int          REG_W          = 16;
  localparam int          ADDR_W         = 4;
  localparam int          SEL_W          = 5;
  localparam int          NUM_PINS       = 26;

  localparam logic [3:0]  OFF_SS_ROUTE   = 4'h0;
  localparam logic [3:0]  OFF_OUT_SEL    = 4'h1;

  localparam int          SS_SEL_LSB     = 0;
  localparam int          PIN0_SEL_LSB   = 0;
  localparam int          PIN1_SEL_LSB   = 8;

  localparam logic [4:0]  SS_SEL_RST     = 5'h1f;
  localparam logic [4:0]  OUT_SEL_RST    = 5'h00;
  localparam logic [4:0]  SS_SEL_MAX_PIN = 5'h19;
  localparam logic [4:0]  OUT_FUNC_NONE  = 5'h00;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [REG_W-1:0]  wdata;
    logic              wr;
    logic              rd;
  } rmps_req_s;

endpackage : rmps_pkg
`default_nettype wire

// ### design/rmps_top.sv
// Remap selector: slave-select input routing and pin 0/1 output function selection.
// Assumes a one-cycle register port and pins synchronous to clock_i.
//
// Behaviour
// [R01] Select field routes pin n to slave-select.
// [R02] Slave-select field bits 4:0, resets all ones.
// [R03] Pin 1 function field bits 12:8, resets zero.
// [R04] Pin 0 function field bits 4:0, resets zero.
// [R05] Unimplemented bits read zero, writes ignored.
// [R06] Function table parameterised; code zero frees pin.
`timescale 1ns/1ps
`default_nettype none
module rmps_top #(
  parameter int NUM_FUNC = 32
) (
  input  wire logic                        clock_i,
  input  wire logic                        srst_i,
  input  wire rmps_pkg::rmps_req_s         req_i,
  output logic [rmps_pkg::REG_W-1:0]       rdata_o,
  input  wire logic [rmps_pkg::NUM_PINS-1:0] pin_in_i,
  output logic                             spi_slave_select_in_o,
  input  wire logic [NUM_FUNC-1:0]         func_out_i,
  input  wire logic [NUM_FUNC-1:0]         func_oe_i,
  output logic [1:0]                       pin_out_o,
  output logic [1:0]                       pin_oe_o,
  output logic [4:0]                       ss_sel_o
);
  import rmps_pkg::*;

  logic [4:0] ss_sel_q;
  logic [4:0] pin0_sel_q;
  logic [4:0] pin1_sel_q;
  logic [4:0] out_sel [2];

  assign out_sel[0] = pin0_sel_q;
  assign out_sel[1] = pin1_sel_q;
  assign ss_sel_o   = ss_sel_q;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ss_sel_q <= SS_SEL_RST; // R02
    end else if (req_i.wr && req_i.addr == OFF_SS_ROUTE) begin
      ss_sel_q <= req_i.wdata[SS_SEL_LSB +: SEL_W]; // R02 R05
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pin0_sel_q <= OUT_SEL_RST; // R04
      pin1_sel_q <= OUT_SEL_RST; // R03
    end else if (req_i.wr && req_i.addr == OFF_OUT_SEL) begin
      pin0_sel_q <= req_i.wdata[PIN0_SEL_LSB +: SEL_W]; // R04
      pin1_sel_q <= req_i.wdata[PIN1_SEL_LSB +: SEL_W]; // R03
    end
  end

  // Unmapped addresses and idle cycles read back zero.
  always_ff @(posedge clock_i) begin
    if (srst_i || !req_i.rd) begin
      rdata_o <= '0;
    end else begin
      case (req_i.addr)
        OFF_SS_ROUTE: rdata_o <= {11'h000, ss_sel_q}; // R05
        OFF_OUT_SEL:  rdata_o <= {3'h0, pin1_sel_q, 3'h0, pin0_sel_q}; // R05
        default:      rdata_o <= '0;
      endcase
    end
  end

  // Reserved codes and the reset code select no pin, so the input rests low.
  always_ff @(posedge clock_i) begin
    if (srst_i || ss_sel_q > SS_SEL_MAX_PIN) begin
      spi_slave_select_in_o <= 1'b0; // R01
    end else begin
      spi_slave_select_in_o <= pin_in_i[ss_sel_q]; // R01
    end
  end

  // Both pins share one function table; a table per pin would cost a wide mux
  // per pin for no gain, since every pin chooses from the same peripheral set.
  for (genvar p = 0; p < 2; p++) begin : g_out
    rmps_out_mux #(
      .NUM_FUNC (NUM_FUNC)
    ) rmps_out_mux_inst (
      .clock_i    (clock_i),
      .srst_i     (srst_i),
      .sel_i      (out_sel[p]),
      .func_out_i (func_out_i),
      .func_oe_i  (func_oe_i),
      .pin_out_o  (pin_out_o[p]),
      .pin_oe_o   (pin_oe_o[p])
    );
  end

  a_ss_route_follow: assert property (@(posedge clock_i) disable iff (srst_i) // R01
    ($past(ss_sel_q) <= SS_SEL_MAX_PIN && !$past(srst_i))
      |-> spi_slave_select_in_o == $past(pin_in_i[ss_sel_q]))
    else $error("slave-select input does not follow chosen pin");

  a_ss_reset_ones: assert property (@(posedge clock_i) // R02
    $past(srst_i) |-> ss_sel_q == SS_SEL_RST)
    else $error("slave-select field not all ones after reset");

  a_pin1_write_lands: assert property (@(posedge clock_i) disable iff (srst_i) // R03
    (req_i.wr && req_i.addr == OFF_OUT_SEL) |=> pin1_sel_q == $past(req_i.wdata[12:8]))
    else $error("pin 1 field did not take written value");

  a_pin0_write_lands: assert property (@(posedge clock_i) disable iff (srst_i) // R04
    (req_i.wr && req_i.addr == OFF_OUT_SEL) |=> pin0_sel_q == $past(req_i.wdata[4:0]))
    else $error("pin 0 field did not take written value");

  a_unimpl_read_zero: assert property (@(posedge clock_i) disable iff (srst_i) // R05
    (req_i.rd && req_i.addr == OFF_OUT_SEL) |=> (rdata_o[15:13] == 3'h0 && rdata_o[7:5] == 3'h0))
    else $error("unimplemented output select bits read nonzero");

  a_ss_upper_zero: assert property (@(posedge clock_i) disable iff (srst_i) // R05
    (req_i.rd && req_i.addr == OFF_SS_ROUTE) |=> rdata_o == {11'h000, $past(ss_sel_q)})
    else $error("input routing readback wrong");

  a_pins_reset_free: assert property (@(posedge clock_i) // R06
    $past(srst_i, 2) && $past(srst_i) |-> pin_oe_o == 2'b00)
    else $error("pins driven after reset");

  a_reg_hold: assert property (@(posedge clock_i) disable iff (srst_i) // R02
    !(req_i.wr && req_i.addr == OFF_SS_ROUTE) |=> $stable(ss_sel_q))
    else $error("slave-select field changed without write");

  // Decoded strobes used only by the checks below; the register processes keep their
  // own decode so that the checks do not share a fault with the logic they watch.
  logic wr_ss_route;
  logic wr_out_sel;
  logic wr_unmapped;
  logic rd_out_sel;
  logic rd_unmapped;

  assign wr_ss_route = req_i.wr && (req_i.addr == OFF_SS_ROUTE);
  assign wr_out_sel  = req_i.wr && (req_i.addr == OFF_OUT_SEL);
  assign wr_unmapped = req_i.wr && (req_i.addr != OFF_SS_ROUTE) && (req_i.addr != OFF_OUT_SEL);
  assign rd_out_sel  = req_i.rd && (req_i.addr == OFF_OUT_SEL);
  assign rd_unmapped = req_i.rd && (req_i.addr != OFF_SS_ROUTE) && (req_i.addr != OFF_OUT_SEL);

  // Each check looks one edge after its cause, because every watched output is registered.
  a_ss_write_lands: assert property (@(posedge clock_i) disable iff (srst_i) // R02
    wr_ss_route
      |=> ss_sel_q == $past(req_i.wdata[SS_SEL_LSB +: SEL_W]))
    else $error("slave-select field did not take written value");

  a_ss_reserved_low: assert property (@(posedge clock_i) disable iff (srst_i) // R01
    ($past(ss_sel_q) > SS_SEL_MAX_PIN)
      |-> !spi_slave_select_in_o)
    else $error("reserved slave-select code let a pin through");

  // Reset values, checked on the first edge after any cycle of reset.
  a_ss_reset_low: assert property (@(posedge clock_i) // R01
    $past(srst_i)
      |-> !spi_slave_select_in_o)
    else $error("slave-select input not low after reset");

  a_pin1_reset_zero: assert property (@(posedge clock_i) // R03
    $past(srst_i)
      |-> pin1_sel_q == OUT_SEL_RST)
    else $error("pin 1 field not zero after reset");

  a_pin0_reset_zero: assert property (@(posedge clock_i) // R04
    $past(srst_i)
      |-> pin0_sel_q == OUT_SEL_RST)
    else $error("pin 0 field not zero after reset");

  a_pin1_field_hold: assert property (@(posedge clock_i) disable iff (srst_i) // R03
    !wr_out_sel
      |=> $stable(pin1_sel_q))
    else $error("pin 1 field changed without write");

  a_pin0_field_hold: assert property (@(posedge clock_i) disable iff (srst_i) // R04
    !wr_out_sel
      |=> $stable(pin0_sel_q))
    else $error("pin 0 field changed without write");

  a_pin1_readback: assert property (@(posedge clock_i) disable iff (srst_i) // R03
    rd_out_sel
      |=> rdata_o[PIN1_SEL_LSB +: SEL_W] == $past(pin1_sel_q))
    else $error("pin 1 field readback wrong");

  a_pin0_readback: assert property (@(posedge clock_i) disable iff (srst_i) // R04
    rd_out_sel
      |=> rdata_o[PIN0_SEL_LSB +: SEL_W] == $past(pin0_sel_q))
    else $error("pin 0 field readback wrong");

  a_unmapped_read_zero: assert property (@(posedge clock_i) disable iff (srst_i) // R05
    rd_unmapped
      |=> rdata_o == '0)
    else $error("unmapped address read nonzero");

  a_unmapped_write_void: assert property (@(posedge clock_i) disable iff (srst_i) // R05
    wr_unmapped
      |=> ($stable(ss_sel_q) && $stable(pin0_sel_q) && $stable(pin1_sel_q)))
    else $error("unmapped address write changed a field");

  // A code at or above NUM_FUNC releases the pin, so the function checks skip it.
  a_pin1_func_follow: assert property (@(posedge clock_i) disable iff (srst_i) // R03
    (!$past(srst_i) && $past(pin1_sel_q) != OUT_FUNC_NONE
      && int'($past(pin1_sel_q)) < NUM_FUNC)
      |-> {pin_oe_o[1], pin_out_o[1]}
        == $past({func_oe_i[pin1_sel_q], func_out_i[pin1_sel_q]}))
    else $error("pin 1 does not carry its selected function");

  a_pin0_func_follow: assert property (@(posedge clock_i) disable iff (srst_i) // R04
    (!$past(srst_i) && $past(pin0_sel_q) != OUT_FUNC_NONE
      && int'($past(pin0_sel_q)) < NUM_FUNC)
      |-> {pin_oe_o[0], pin_out_o[0]}
        == $past({func_oe_i[pin0_sel_q], func_out_i[pin0_sel_q]}))
    else $error("pin 0 does not carry its selected function");

  a_pin1_free_low: assert property (@(posedge clock_i) disable iff (srst_i) // R06
    ($past(pin1_sel_q) == OUT_FUNC_NONE)
      |-> !pin_out_o[1])
    else $error("pin 1 output level set while function code is zero");

  a_pin0_free_low: assert property (@(posedge clock_i) disable iff (srst_i) // R06
    ($past(pin0_sel_q) == OUT_FUNC_NONE)
      |-> !pin_out_o[0])
    else $error("pin 0 output level set while function code is zero");

endmodule : rmps_top
`default_nettype wire

// ### testbench/rmps_periph_model.sv
// Far-side model: remappable pin levels and peripheral output functions.
// Assumes the bench sets pin levels at clock edges.
`timescale 1ns/1ps
`default_nettype none
module rmps_periph_model (
  input  wire logic [25:0] pin_lvl_i,
  output logic      [25:0] pin_in_o,
  output logic      [31:0] func_out_o,
  output logic      [31:0] func_oe_o
);
  // Functions 3 and 5 differ in level so a swapped field shows.
  assign pin_in_o   = pin_lvl_i;
  assign func_out_o = 32'h0000_0008;
  assign func_oe_o  = 32'h0000_0028;
endmodule : rmps_periph_model
`default_nettype wire

// ### testbench/rmps_top_tb.sv
// Testbench for the remap selector, driving the register port directly.
// Assumes the far-side model in rmps_periph_model.
`timescale 1ns/1ps
`default_nettype none
module rmps_top_tb;
  import rmps_pkg::*;
  logic        clock_i, srst_i, ss_in;
  rmps_req_s   req;
  logic [15:0] rdata;
  logic [25:0] pin_in, lvl;
  logic [31:0] fo, foe;
  logic [1:0]  p_out, p_oe;
  logic [4:0]  ss_sel;
  int          err_count, checked;
  rmps_top rmps_top_inst (.clock_i(clock_i), .srst_i(srst_i), .req_i(req), .rdata_o(rdata),
    .pin_in_i(pin_in), .spi_slave_select_in_o(ss_in), .func_out_i(fo), .func_oe_i(foe),
    .pin_out_o(p_out), .pin_oe_o(p_oe), .ss_sel_o(ss_sel));
  rmps_periph_model rmps_periph_model_inst (.pin_lvl_i(lvl), .pin_in_o(pin_in),
    .func_out_o(fo), .func_oe_o(foe));
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock_i);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock_i);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clock_i);
    req.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd
  task automatic settle;
    repeat (2) @(posedge clock_i);
    #1;
  endtask : settle
  task automatic results;
    $display("errors=%0d checks=%0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  initial begin
    #20000;
    err_count++;
    results();
  end
  initial begin
    req = '0;
    lvl = 26'h0;
    srst_i = 1'b1;
    err_count = 0;
    checked = 0;
    repeat (3) @(posedge clock_i);
    srst_i <= 1'b0;
    rd(4'h0, 16'h001f);
    rd(4'h1, 16'h0000);
    chk({11'h0, ss_sel}, 16'h001f);
    chk({12'h0, p_oe, p_out}, 16'h0000);
    wr(4'h0, 16'hffe0);
    rd(4'h0, 16'h0000);
    wr(4'h1, 16'hffff);
    rd(4'h1, 16'h1f1f);
    rd(4'h2, 16'h0000);
    wr(4'h3, 16'h0000);
    rd(4'h1, 16'h1f1f);
    for (int n = 0; n < 26; n++) begin
      wr(4'h0, 16'(n));
      lvl <= 26'h1 << n;
      settle();
      chk({15'h0, ss_in}, 16'h0001);
      @(posedge clock_i);
      lvl <= ~(26'h1 << n);
      settle();
      chk({15'h0, ss_in}, 16'h0000);
    end
    wr(4'h0, 16'h001a);
    lvl <= '1;
    settle();
    chk({15'h0, ss_in}, 16'h0000);
    wr(4'h1, 16'h0305);
    settle();
    chk({12'h0, p_oe, p_out}, 16'h000e);
    wr(4'h1, 16'h0503);
    settle();
    chk({12'h0, p_oe, p_out}, 16'h000d);
    wr(4'h1, 16'h0300);
    settle();
    chk({12'h0, p_oe, p_out}, 16'h000a);
    @(posedge clock_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    srst_i <= 1'b0;
    settle();
    chk({15'h0, ss_in}, 16'h0000);
    chk({12'h0, p_oe, p_out}, 16'h0000);
    rd(4'h0, 16'h001f);
    rd(4'h1, 16'h0000);
    results();
  end
endmodule : rmps_top_tb
`default_nettype wire
